// File: core/dadc_pkg.sv
package dadc_pkg;
  localparam int          SMP_W     = 14;          // Sample word width.
  localparam int          LAT_EDGES = 33;          // 16.5 sample clocks as half-cycles.
  localparam int          MCLK_MHZ  = 200;
  localparam int          GAP_NS    = 400;         // Longest gap between sample clock edges.
  localparam int          GAP_CYC   = GAP_NS * MCLK_MHZ / 1000;
  localparam int          GAP_W     = 8;
  localparam int          AW        = 12;
  localparam int          DW        = 32;
  localparam int          ST_W      = 3;
  localparam logic [13:0] FS_MAX    = 14'h1FFF;
  localparam logic [13:0] FS_MIN    = 14'h2000;
  localparam logic [11:0] OFS_STAT  = 12'h000;
  localparam logic [11:0] OFS_MASK  = 12'h004;
  localparam logic [11:0] OFS_STATE = 12'h008;
  localparam int          ST_OVR_A  = 0;
  localparam int          ST_OVR_B  = 1;
  localparam int          ST_SLEEP  = 2;
  localparam logic [2:0]  MASK_RST  = 3'h0;

  typedef struct packed {
    logic             valid;
    logic [SMP_W-1:0] word;
  } dadc_smp_t;

  typedef struct packed {
    logic clk_slow;
    logic core_b;
    logic core_a;
    logic oe_b;
    logic oe_a;
  } dadc_state_t;
endpackage : dadc_pkg

// File: core/dadc_top.sv
`timescale 1ns/10ps

module dadc_chan #(
  parameter int DEPTH = dadc_pkg::LAT_EDGES
) (
  input  wire logic                       clk_in,    // System clock.
  input  wire logic                       rst_in,    // Synchronous reset.
  input  wire logic                       edge_in,   // Any sample clock edge.
  input  wire logic                       fall_in,   // Falling sample clock edge.
  input  wire logic                       run_in,    // Core powered.
  input  wire logic [dadc_pkg::SMP_W-1:0] sample_in, // Quantised analog value.
  output logic      [dadc_pkg::SMP_W-1:0] data_out,  // Output word.
  output logic                            strobe_out,// New word pulse.
  output logic                            ovr_out    // Overrange flag.
);
  import dadc_pkg::*;

  dadc_smp_t pipe [DEPTH];

  // Each stage is one half-cycle of the sample clock, so the word walks the pipe on both edges.
  always_ff @(posedge clk_in) begin
    if (rst_in || !run_in) begin
      for (int i = 0; i < DEPTH; i++) begin
        pipe[i] <= '0;
      end
    end else if (edge_in) begin
      pipe[0] <= '{valid: fall_in, word: sample_in};
      for (int i = 1; i < DEPTH; i++) begin
        pipe[i] <= pipe[i-1];
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      data_out   <= '0;
      strobe_out <= 1'b0;
      ovr_out    <= 1'b0;
    end else begin
      strobe_out <= edge_in && run_in && pipe[DEPTH-1].valid;
      if (edge_in && run_in && pipe[DEPTH-1].valid) begin
        data_out <= pipe[DEPTH-1].word;
        ovr_out  <= (pipe[DEPTH-1].word == FS_MAX) || (pipe[DEPTH-1].word == FS_MIN);
      end
    end
  end

  property p_ovr_fs;
    @(posedge clk_in) disable iff (rst_in)
    ovr_out == ((data_out == FS_MAX) || (data_out == FS_MIN));
  endproperty
  a_ovr_fs: assert property (p_ovr_fs) else $error("Overrange flag disagrees with word.");

  sequence s_word_out;
    edge_in && run_in && pipe[DEPTH-1].valid;
  endsequence
  property p_word_strobe;
    @(posedge clk_in) disable iff (rst_in)
    s_word_out |=> strobe_out && data_out == $past(pipe[DEPTH-1].word);
  endproperty
  a_word_strobe: assert property (p_word_strobe) else $error("Word not presented with strobe.");

  property p_strobe_cause;
    @(posedge clk_in) disable iff (rst_in)
    strobe_out |-> $past(edge_in) && $past(run_in);
  endproperty
  a_strobe_cause: assert property (p_strobe_cause) else $error("Strobe without clock edge.");

  property p_fall_only;
    @(posedge clk_in) disable iff (rst_in)
    edge_in && run_in && !fall_in |=> !pipe[0].valid;
  endproperty
  a_fall_only: assert property (p_fall_only) else $error("Sample taken on rising edge.");
endmodule : dadc_chan

module dadc_top (
  input  wire logic                       mclk_in,                // 200 MHz system clock.
  input  wire logic                       rst_in,                 // Synchronous reset.
  input  wire logic                       sample_clk_in,          // Sample clock level.
  input  wire logic                       sleep_select_in,        // Power-down mode select.
  input  wire logic                       chan_a_drive_enable_in, // Channel A bus enable.
  input  wire logic                       chan_b_drive_enable_in, // Channel B bus enable.
  input  wire logic [dadc_pkg::SMP_W-1:0] chan_a_sample_in,       // Channel A core value.
  input  wire logic [dadc_pkg::SMP_W-1:0] chan_b_sample_in,       // Channel B core value.
  output logic      [dadc_pkg::SMP_W-1:0] chan_a_data_out,        // Channel A word.
  output logic      [dadc_pkg::SMP_W-1:0] chan_b_data_out,        // Channel B word.
  output logic                            chan_a_sample_valid_strobe_out, // A data ready.
  output logic                            chan_b_sample_valid_strobe_out, // B data ready.
  output logic                            chan_a_overrange_flag_out,      // A overrange.
  output logic                            chan_b_overrange_flag_out,      // B overrange.
  output logic                            chan_a_oe_out,          // Drives all A output pins.
  output logic                            chan_b_oe_out,          // Drives all B output pins.
  input  wire logic                       psel_in,                // APB select.
  input  wire logic                       penable_in,             // APB enable.
  input  wire logic                       pwrite_in,              // APB write.
  input  wire logic [dadc_pkg::AW-1:0]    paddr_in,               // APB byte address.
  input  wire logic [dadc_pkg::DW-1:0]    pwdata_in,              // APB write data.
  output logic      [dadc_pkg::DW-1:0]    prdata_out,             // APB read data.
  output logic                            pready_out,             // APB ready.
  output logic                            pslverr_out,            // APB error.
  output logic                            irq_out                 // Level interrupt.
);
  import dadc_pkg::*;

  logic             clk_prev;
  logic             s_rise;
  logic             s_fall;
  logic             s_edge;
  logic [GAP_W-1:0] gap;
  logic             clk_slow;
  logic             slow_prev;
  logic             core_a;
  logic             core_b;
  logic [ST_W-1:0]  status;
  logic [ST_W-1:0]  mask;
  logic [ST_W-1:0]  rd_clr;
  logic [ST_W-1:0]  ev;
  logic             setup;
  logic             access;
  logic             mapped;
  dadc_state_t      state;

  assign s_rise = sample_clk_in && !clk_prev;
  assign s_fall = !sample_clk_in && clk_prev;
  assign s_edge = s_rise || s_fall;
  assign setup  = psel_in && !penable_in;
  assign access = psel_in && penable_in && pready_out;
  assign mapped = paddr_in == OFS_STAT || paddr_in == OFS_MASK || paddr_in == OFS_STATE;
  assign state  = '{clk_slow: clk_slow, core_b: core_b, core_a: core_a,
                    oe_b: chan_b_oe_out, oe_a: chan_a_oe_out};

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      clk_prev <= 1'b0;
    end else begin
      clk_prev <= sample_clk_in;
    end
  end

  // A missing edge for longer than the gap means the sample clock is below about 1.25 MHz.
  always_ff @(posedge mclk_in) begin
    if (rst_in || s_edge) begin
      gap <= '0;
    end else if (gap != GAP_W'(GAP_CYC)) begin
      gap <= gap + GAP_W'(1);
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      clk_slow  <= 1'b0;
      slow_prev <= 1'b0;
    end else begin
      clk_slow  <= (gap == GAP_W'(GAP_CYC)) && !s_edge;
      slow_prev <= clk_slow;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      core_a        <= 1'b0;
      core_b        <= 1'b0;
      chan_a_oe_out <= 1'b0;
      chan_b_oe_out <= 1'b0;
    end else begin
      core_a        <= !clk_slow && (!sleep_select_in || chan_a_drive_enable_in);
      core_b        <= !clk_slow && (!sleep_select_in || chan_b_drive_enable_in);
      chan_a_oe_out <= chan_a_drive_enable_in;
      chan_b_oe_out <= chan_b_drive_enable_in;
    end
  end

  dadc_chan #(.DEPTH(LAT_EDGES)) u_chan_a (
    .clk_in     (mclk_in),
    .rst_in     (rst_in),
    .edge_in    (s_edge),
    .fall_in    (s_fall),
    .run_in     (core_a),
    .sample_in  (chan_a_sample_in),
    .data_out   (chan_a_data_out),
    .strobe_out (chan_a_sample_valid_strobe_out),
    .ovr_out    (chan_a_overrange_flag_out)
  );

  dadc_chan #(.DEPTH(LAT_EDGES)) u_chan_b (
    .clk_in     (mclk_in),
    .rst_in     (rst_in),
    .edge_in    (s_edge),
    .fall_in    (s_fall),
    .run_in     (core_b),
    .sample_in  (chan_b_sample_in),
    .data_out   (chan_b_data_out),
    .strobe_out (chan_b_sample_valid_strobe_out),
    .ovr_out    (chan_b_overrange_flag_out)
  );

  always_comb begin
    ev           = '0;
    ev[ST_OVR_A] = chan_a_sample_valid_strobe_out && chan_a_overrange_flag_out;
    ev[ST_OVR_B] = chan_b_sample_valid_strobe_out && chan_b_overrange_flag_out;
    ev[ST_SLEEP] = clk_slow && !slow_prev;
    rd_clr       = '0;
    if (access && !pwrite_in && paddr_in == OFS_STAT) begin
      rd_clr = prdata_out[ST_W-1:0];
    end
  end

  // Only bits that were actually returned are cleared, and a new event wins over the clear.
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      status <= '0;
    end else begin
      status <= (status & ~rd_clr) | ev;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      mask <= MASK_RST;
    end else if (access && pwrite_in && paddr_in == OFS_MASK) begin
      mask <= pwdata_in[ST_W-1:0];
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(status & mask);
    end
  end

  // Ready and read data are registered in the setup cycle, so every access takes one wait-free
  // access cycle.
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out  <= '0;
    end else begin
      pready_out  <= setup;
      pslverr_out <= setup && !mapped;
      if (setup && !pwrite_in) begin
        unique case (paddr_in)
          OFS_STAT:  prdata_out <= DW'(status);
          OFS_MASK:  prdata_out <= DW'(mask);
          OFS_STATE: prdata_out <= DW'(state);
          default:   prdata_out <= '0;
        endcase
      end else if (!psel_in) begin
        prdata_out <= '0;
      end
    end
  end

  property p_awake;
    @(posedge mclk_in) disable iff (rst_in)
    !sleep_select_in && !clk_slow |=> core_a && core_b;
  endproperty
  a_awake: assert property (p_awake) else $error("Core off while sleep select low.");

  property p_sleep_gate;
    @(posedge mclk_in) disable iff (rst_in)
    sleep_select_in && !chan_a_drive_enable_in |=> !core_a ##1 !chan_a_sample_valid_strobe_out;
  endproperty
  a_sleep_gate: assert property (p_sleep_gate) else $error("Disabled core still runs.");

  property p_oe;
    @(posedge mclk_in) disable iff (rst_in)
    ##1 chan_a_oe_out == $past(chan_a_drive_enable_in) &&
        chan_b_oe_out == $past(chan_b_drive_enable_in);
  endproperty
  a_oe: assert property (p_oe) else $error("Output enable does not follow drive enable.");

  property p_slow;
    @(posedge mclk_in) disable iff (rst_in)
    !s_edge [*8] ##0 gap == GAP_W'(GAP_CYC) |=> clk_slow ##1 !core_a && !core_b;
  endproperty
  a_slow: assert property (p_slow) else $error("No power-down on stopped clock.");

  property p_irq;
    @(posedge mclk_in) disable iff (rst_in)
    ##1 irq_out == $past(|(status & mask));
  endproperty
  a_irq: assert property (p_irq) else $error("Interrupt disagrees with status and mask.");

  property p_both_off;
    @(posedge mclk_in) disable iff (rst_in)
    sleep_select_in && !chan_a_drive_enable_in && !chan_b_drive_enable_in |=> !core_a && !core_b;
  endproperty
  a_both_off: assert property (p_both_off) else $error("Core on with both enables low.");

  property p_core_b_run;
    @(posedge mclk_in) disable iff (rst_in)
    sleep_select_in && chan_b_drive_enable_in && !clk_slow |=> core_b;
  endproperty
  a_core_b_run: assert property (p_core_b_run) else $error("Enabled core B is off.");

  // The power-down must end on the first edge, otherwise the first word after a stop is lost.
  property p_wake;
    @(posedge mclk_in) disable iff (rst_in)
    clk_slow && s_edge |=> !clk_slow;
  endproperty
  a_wake: assert property (p_wake) else $error("Power-down held after a clock edge.");

  property p_ready_pulse;
    @(posedge mclk_in) disable iff (rst_in)
    pready_out |=> !pready_out;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("Ready held for two cycles.");

  property p_err_ready;
    @(posedge mclk_in) disable iff (rst_in)
    pslverr_out |-> pready_out;
  endproperty
  a_err_ready: assert property (p_err_ready) else $error("Error without ready.");

  property p_mask_write;
    @(posedge mclk_in) disable iff (rst_in)
    access && pwrite_in && paddr_in == OFS_MASK |=> mask == $past(pwdata_in[ST_W-1:0]);
  endproperty
  a_mask_write: assert property (p_mask_write) else $error("Mask write did not land.");

  property p_sticky;
    @(posedge mclk_in) disable iff (rst_in)
    status[ST_SLEEP] && !rd_clr[ST_SLEEP] |=> status[ST_SLEEP];
  endproperty
  a_sticky: assert property (p_sticky) else $error("Status bit dropped without a read.");

  // A read clears only what it returned; an event in the same cycle must survive.
  sequence s_stat_read;
    access && !pwrite_in && paddr_in == OFS_STAT;
  endsequence
  property p_rd_clear;
    @(posedge mclk_in) disable iff (rst_in)
    s_stat_read |=> (status & $past(rd_clr & ~ev)) == '0;
  endproperty
  a_rd_clear: assert property (p_rd_clear) else $error("Status read did not clear.");
endmodule : dadc_top

// File: tb/dadc_capture.sv
`timescale 1ns/10ps
module dadc_capture (
  input  wire logic                       mclk_in,   // System clock.
  input  wire logic                       strobe_in, // Data-ready strobe.
  input  wire logic                       oe_in,     // Channel pins driven.
  input  wire logic [dadc_pkg::SMP_W-1:0] data_in,   // Sample word.
  input  wire logic                       ovr_in,    // Overrange flag.
  output logic                            cap_out,   // Word taken this cycle.
  output logic      [dadc_pkg::SMP_W-1:0] word_out,  // Taken word.
  output logic                            ovr_out    // Taken flag.
);
  import dadc_pkg::*;
  // A disabled channel floats its pins, so nothing is taken from it.
  always_ff @(posedge mclk_in) begin
    cap_out <= strobe_in & oe_in;
    if (strobe_in && oe_in) begin
      word_out <= data_in;
      ovr_out  <= ovr_in;
    end
  end
endmodule : dadc_capture

// File: tb/tb_dual_adc_output_powerdown.sv
`timescale 1ns/10ps
module tb_dual_adc_output_powerdown;
  import dadc_pkg::*;
  typedef struct packed {
    logic [31:0]      e;
    logic [SMP_W-1:0] w;
  } dadc_note_t;
  logic             mclk_in = 0, rst_in = 1, sclk = 1, sleep = 0, en_a = 0, en_b = 0;
  logic [SMP_W-1:0] sa = 14'h0000, sb = 14'h0000, va, vb, da, db, wa, wb;
  logic             sta, stb, oa, ob, chan_a_drive_enable, chan_b_drive_enable, ca, cb, fa, fb, irq, rdy, serr, er;
  logic             psel = 0, penable = 0, pwrite = 0;
  logic [AW-1:0]    paddr = 12'h000;
  logic [DW-1:0]    pwdata = 32'h00000000, rd, prd, lfsr = 32'hF479CEB9;
  logic [31:0]      ecnt = 0, stop_at = 0;
  int               dv = 0, fcnt = 0, miscompares = 0, total_checks = 0;
  dadc_note_t       qa[$], qb[$];

  always #2.5 mclk_in = ~mclk_in;

  dadc_top uut (.mclk_in(mclk_in), .rst_in(rst_in), .sample_clk_in(sclk),
    .sleep_select_in(sleep), .chan_a_drive_enable_in(en_a), .chan_b_drive_enable_in(en_b),
    .chan_a_sample_in(sa), .chan_b_sample_in(sb), .chan_a_data_out(da), .chan_b_data_out(db),
    .chan_a_sample_valid_strobe_out(sta), .chan_b_sample_valid_strobe_out(stb),
    .chan_a_overrange_flag_out(oa), .chan_b_overrange_flag_out(ob),
    .chan_a_oe_out(chan_a_drive_enable), .chan_b_oe_out(chan_b_drive_enable), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prd),
    .pready_out(rdy), .pslverr_out(serr), .irq_out(irq));
  dadc_capture cap_a (.mclk_in(mclk_in), .strobe_in(sta), .oe_in(chan_a_drive_enable), .data_in(da),
    .ovr_in(oa), .cap_out(ca), .word_out(wa), .ovr_out(fa));
  dadc_capture cap_b (.mclk_in(mclk_in), .strobe_in(stb), .oe_in(chan_b_drive_enable), .data_in(db),
    .ovr_in(ob), .cap_out(cb), .word_out(wb), .ovr_out(fb));

  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nxt

  task automatic chk(input logic [31:0] got, input logic [31:0] want, input string m);
    total_checks++;
    if (got !== want) begin
      miscompares++;
      $display("[ERR] %0t %s got %h want %h", $time, m, got, want);
    end
  endtask : chk

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict

  task automatic take(ref dadc_note_t q[$], input logic [SMP_W-1:0] w, input logic f);
    dadc_note_t n;
    if (q.size() == 0) chk(32'h1, 32'h0, "word with nothing pending");
    else begin
      n = q.pop_front();
      chk(32'(w), 32'(n.w), "word");
      chk(32'(f), 32'((n.w === FS_MAX) || (n.w === FS_MIN)), "overrange");
      chk(ecnt - n.e, 32'h21, "latency in sample edges");
    end
  endtask : take

  task automatic apb(input logic w, input logic [AW-1:0] a, input logic [DW-1:0] d);
    int n;
    @(posedge mclk_in);
    psel    <= 1;
    penable <= 0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk_in);
    penable <= 1;
    n = 0;
    @(negedge mclk_in);
    while (rdy !== 1'b1 && n < 20) begin
      @(negedge mclk_in);
      n++;
    end
    rd = prd;
    er = serr;
    @(posedge mclk_in);
    psel    <= 0;
    penable <= 0;
    if (n == 20) begin
      miscompares++;
      print_verdict();
    end
  endtask : apb

  // The sample clock stands still between bursts; a long stop forces power-down.
  always @(posedge mclk_in) begin
    if (ecnt != stop_at) begin
      dv <= (dv == 3) ? 0 : dv + 1;
      if (dv == 3) begin
        sclk <= ~sclk;
        ecnt <= ecnt + 1;
        if (sclk) begin
          lfsr = nxt(lfsr);
          fcnt = fcnt + 1;
          va = (fcnt % 4 == 0) ? FS_MAX : lfsr[13:0];
          vb = (fcnt % 4 == 2) ? FS_MIN : lfsr[27:14];
          sa <= va;
          sb <= vb;
          if (en_a) qa.push_back('{ecnt + 1, va});
          if (en_b) qb.push_back('{ecnt + 1, vb});
        end
      end
    end
  end

  always @(negedge mclk_in) begin
    if (ca === 1'b1) take(qa, wa, fa);
    if (cb === 1'b1) take(qb, wb, fb);
    if ((sta === 1'b1 && sleep && !en_a) || (stb === 1'b1 && sleep && !en_b))
      chk(32'h1, 32'h0, "strobe from a sleeping core");
  end

  initial begin
    int m;
    int n;
    repeat (5) @(posedge mclk_in);
    rst_in <= 0;
    apb(0, OFS_MASK, 32'h00000000);
    chk(rd, 32'(MASK_RST), "mask reset value");
    apb(0, 12'h00C, 32'h00000000);
    chk(32'(er), 32'h1, "unmapped error");
    chk(rd, 32'h0, "unmapped data");
    for (m = 0; m < 8; m++) begin
      sleep <= m[2];
      en_a  <= m[1];
      en_b  <= m[0];
      apb(1, OFS_MASK, m[0] ? 32'h00000007 : 32'h00000000);
      chk(32'({chan_b_drive_enable, chan_a_drive_enable}), 32'(m[1:0]) ^ 32'(m[1] ^ m[0]) * 3, "pin enables");
      qa.delete();
      qb.delete();
      stop_at <= 61 + 60 * m;
      @(posedge mclk_in);
      for (n = 0; n < 400 && ecnt != stop_at; n++) @(posedge mclk_in);
      if (n == 400) begin
        miscompares++;
        print_verdict();
      end
      repeat (100) @(posedge mclk_in);
      chk(32'(qa.size()), m[1] ? 32'h11 : 32'h0, "words lost in flush A");
      chk(32'(qb.size()), m[0] ? 32'h11 : 32'h0, "words lost in flush B");
      apb(0, OFS_STATE, 32'h00000000);
      chk(rd, {27'h0, 3'h4, m[0], m[1]}, "state while slow");
      chk(32'(irq), 32'(m[0]), "irq masking");
      apb(0, OFS_STAT, 32'h00000000);
      chk(rd, {29'h0, 1'b1, !m[2] || m[0], !m[2] || m[1]}, "status");
      repeat (3) @(posedge mclk_in);
      chk(32'(irq), 32'h0, "irq after status read");
      $display("mode %0d done", m);
    end
    print_verdict();
  end
endmodule : tb_dual_adc_output_powerdown
